/* lscr_regs.sv */
`timescale 1ns/1ps
module lscr_regs (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // register port from the serial interface
  input  wire logic                          wrStrobe,
  input  wire logic                          rdStrobe,
  input  wire logic [7:0]                    regAddr,
  input  wire logic [7:0]                    wrData,
  output logic      [7:0]                    rdData,
  output logic                               rdValid,
  // backlight state from elsewhere
  input  wire logic                          darkAmbient,
  input  wire logic                          dimFlag,
  input  wire logic                          dimTimeout,
  // current and fade outputs
  output logic      [lscr_pkg::CodeWidth-1:0] darkCode,
  output logic                               darkDacSquare,
  output logic                               sinkDacSquare,
  output logic      [1:0]                    sinkStepProfile,
  output logic      [lscr_pkg::NumSinks-1:0] sinkOn
);
  import lscr_pkg::*;

  typedef struct packed {
    logic [6:0]  darkMax;
    logic [6:0]  darkDim;
    logic [1:0]  fadeLaw;
    logic [6:0]  sinkEnable;
    logic [7:0]  sinkTimeOn;
    logic [7:0]  sinkTimeLow;
    logic [7:0]  rdData;
    logic        rdValid;
    logic [6:0]  darkCode;
    logic        sinkSquare;
    logic [1:0]  stepProfile;
    logic [6:0]  restart;
    logic [$clog2(TickCycles)-1:0] tickCount;
    logic        tick;
    logic        dimSync1;
    logic        dimSync2;
    logic        toSync1;
    logic        toSync2;
    logic        darkSync1;
    logic        darkSync2;
    logic [NumSinks-1:0] sinkOut;
  } lscr_state_t;

  lscr_state_t cur, next_cur;
  logic [NumSinks-1:0] timerOut;
  logic [13:0] offFields;

  // 2-bit off-interval field per sink, sink 1 in the lowest pair
  assign offFields = {cur.sinkTimeOn[5:0], cur.sinkTimeLow};

  always_comb begin
    next_cur = cur;
    next_cur.rdValid = 1'b0;
    next_cur.restart = 7'h00;
    next_cur.tick = 1'b0;
    next_cur.dimSync1 = dimFlag;
    next_cur.dimSync2 = cur.dimSync1;
    next_cur.toSync1 = dimTimeout;
    next_cur.toSync2 = cur.toSync1;
    next_cur.darkSync1 = darkAmbient;
    next_cur.darkSync2 = cur.darkSync1;
    next_cur.sinkOut = timerOut;
    if (cur.tickCount == $bits(cur.tickCount)'(TickCycles - 1)) begin
      next_cur.tickCount = '0;
      next_cur.tick = 1'b1;
    end else next_cur.tickCount = cur.tickCount + 1'b1;
    if (wrStrobe) begin
      case (regAddr)
        DarkMaxOffset:     next_cur.darkMax = wrData[6:0];
        DarkDimOffset:     next_cur.darkDim = wrData[6:0];
        FadeLawOffset:     next_cur.fadeLaw = wrData[1:0];
        SinkEnableOffset: begin
          next_cur.sinkEnable = wrData[6:0];
          // newly enabled sinks start their sequence together
          next_cur.restart = wrData[6:0] & ~cur.sinkEnable;
        end
        SinkTimeOnOffset:  next_cur.sinkTimeOn = wrData;
        SinkTimeLowOffset: next_cur.sinkTimeLow = wrData;
        default: ;
      endcase
    end
    if (rdStrobe) begin
      next_cur.rdValid = 1'b1;
      case (regAddr)
        DarkMaxOffset:     next_cur.rdData = {1'b0, cur.darkMax};
        DarkDimOffset:     next_cur.rdData = {1'b0, cur.darkDim};
        FadeLawOffset:     next_cur.rdData = {6'h00, cur.fadeLaw};
        SinkEnableOffset:  next_cur.rdData = {1'b0, cur.sinkEnable};
        SinkTimeOnOffset:  next_cur.rdData = cur.sinkTimeOn;
        SinkTimeLowOffset: next_cur.rdData = cur.sinkTimeLow;
        default:           next_cur.rdData = ResetValue;
      endcase
    end
    // dim code wins on user flag or timeout while darkAmbient is set; only the dark level lives here
    if (cur.darkSync2 && (cur.dimSync2 || cur.toSync2))
      next_cur.darkCode = cur.darkDim;
    else
      next_cur.darkCode = cur.darkMax;
    next_cur.sinkSquare = (lscr_law_t'(cur.fadeLaw) != LSCR_LIN_LIN);
    case (lscr_law_t'(cur.fadeLaw))
      LSCR_SQ_CUBIC_A: next_cur.stepProfile = LSCR_STEP_CUBIC_A;
      LSCR_SQ_CUBIC_B: next_cur.stepProfile = LSCR_STEP_CUBIC_B;
      default:         next_cur.stepProfile = LSCR_STEP_LINEAR;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) next_reset: cur <= '0;
    else cur <= next_cur;
  end

  genvar n;
  generate
    for (n = 0; n < NumSinks; n++) begin : g_sink
      lscr_sink_if sinkBus ();
      assign sinkBus.enable = cur.sinkEnable[n];
      assign sinkBus.restart = cur.restart[n];
      assign sinkBus.tick = cur.tick;
      assign sinkBus.onSel = cur.sinkTimeOn[7:6];
      assign sinkBus.offSel = offFields[2*n+1:2*n];
      assign timerOut[n] = sinkBus.sinkOn;
      lscr_sink_timer u_timer (
        .sysClk (sys_clk),
        .rst_n  (rst_n),
        .sink   (sinkBus)
      );
    end
  endgenerate

  assign sinkOn = cur.sinkOut;
  assign rdData = cur.rdData;
  assign rdValid = cur.rdValid;
  assign darkCode = cur.darkCode;
  assign darkDacSquare = cur.sinkSquare;
  assign sinkDacSquare = cur.sinkSquare;
  assign sinkStepProfile = cur.stepProfile;

  // checks
  sequence enWrite_s;
    wrStrobe && regAddr == SinkEnableOffset;
  endsequence
  sequence readBack_s;
    rdStrobe && regAddr == SinkEnableOffset;
  endsequence
  reserved_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rdStrobe && regAddr == FadeLawOffset) |=> (rdValid && rdData[7:2] == 6'h00))
    else $error("reserved bit read as one");
  max_reserved_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rdStrobe && regAddr == DarkMaxOffset) |=> (rdValid && !rdData[7]))
    else $error("max code reserved bit set");
  // host strobes come at most every other cycle, so the read lands two cycles on
  enable_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (enWrite_s ##1 !wrStrobe ##1 (!wrStrobe and readBack_s))
      |=> rdData == ($past(wrData, 3) & SinkMask))
    else $error("sink enable readback mismatch");
  law_square_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wrStrobe && regAddr == FadeLawOffset && wrData[1:0] == 2'h0) |=> ##1 !sinkDacSquare)
    else $error("linear law gave square dac");
  law_cubic_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wrStrobe && regAddr == FadeLawOffset && wrData[1]) |=> ##1 (sinkDacSquare
      && sinkStepProfile != LSCR_STEP_LINEAR))
    else $error("cubic law not applied");
  dim_select_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cur.darkSync2 && cur.dimSync2) |=> darkCode == $past(cur.darkDim))
    else $error("dim code not selected");
  timeout_select_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cur.darkSync2 && cur.toSync2) |=> darkCode == $past(cur.darkDim))
    else $error("dim timeout ignored");
  max_select_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!cur.dimSync2 && !cur.toSync2) |=> darkCode == $past(cur.darkMax))
    else $error("max code not selected");
  sink_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (enWrite_s and (wrData[0] == 1'b0)) |=> ##3 !sinkOn[0])
    else $error("sink 1 still on after disable");
endmodule // lscr_regs

/* lscr_pkg.sv */
package lscr_pkg;
  // register offsets on the serial control port
  localparam logic [7:0] DarkMaxOffset     = 8'h0D;
  localparam logic [7:0] DarkDimOffset     = 8'h0E;
  localparam logic [7:0] FadeLawOffset     = 8'h0F;
  localparam logic [7:0] SinkEnableOffset  = 8'h10;
  localparam logic [7:0] SinkTimeOnOffset  = 8'h11;
  localparam logic [7:0] SinkTimeLowOffset = 8'h12;
  localparam int         CodeWidth         = 7;
  localparam int         NumSinks          = 7;
  localparam logic [7:0] CodeMask          = 8'h7F;
  localparam logic [7:0] LawMask           = 8'h03;
  localparam logic [7:0] SinkMask          = 8'h7F;
  localparam logic [7:0] ResetValue        = 8'h00;
  localparam logic [6:0] CodeZero          = 7'h00;
  localparam logic [6:0] CodeFull          = 7'h7F;
  // on/off interval in units of 0.2 s, clock 25 MHz
  localparam int         ClockHz           = 25000000;
  localparam int         TickMs            = 200;
  localparam int         TickCycles        = ClockHz / 1000 * TickMs;
  localparam logic [1:0] OffDisabled       = 2'h0;
  typedef enum logic [1:0] {
    LSCR_LIN_LIN, LSCR_SQ_LIN, LSCR_SQ_CUBIC_A, LSCR_SQ_CUBIC_B
  } lscr_law_t;
  typedef enum logic {LSCR_DAC_LINEAR, LSCR_DAC_SQUARE} lscr_dac_t;
  typedef enum logic [1:0] {LSCR_STEP_LINEAR, LSCR_STEP_CUBIC_A, LSCR_STEP_CUBIC_B} lscr_step_t;
endpackage

/* lscr_sink_if.sv */
`timescale 1ns/1ps
interface lscr_sink_if;
  logic       enable;
  logic       restart;
  logic       tick;
  logic [1:0] onSel;
  logic [1:0] offSel;
  logic       sinkOn;
  modport ctrl (output enable, output restart, output tick, output onSel, output offSel,
                input sinkOn);
  modport timer (input enable, input restart, input tick, input onSel, input offSel,
                 output sinkOn);
endinterface

/* lscr_sink_timer.sv */
`timescale 1ns/1ps
module lscr_sink_timer (
  // clock and reset
  input wire logic  sysClk,
  input wire logic  rst_n,
  // control
  lscr_sink_if.timer sink
);
  import lscr_pkg::*;
  typedef enum logic {LSCR_ON, LSCR_OFF} lscr_phase_t;
  typedef struct packed {
    lscr_phase_t phase;
    logic [3:0]  count;
    logic        out;
  } lscr_tmr_t;
  lscr_tmr_t cur, next_cur;
  logic [3:0] onTicks, offTicks;

  always_comb begin
    case (sink.onSel)
      2'h0:    onTicks = 4'h1;
      2'h1:    onTicks = 4'h3;
      2'h2:    onTicks = 4'h4;
      default: onTicks = 4'h6;
    endcase
    offTicks = {1'b0, sink.offSel, 1'b0} + {2'h0, sink.offSel};
    next_cur = cur;
    if (!sink.enable || sink.restart) begin
      next_cur.phase = LSCR_ON;
      next_cur.count = 4'h0;
    end else if (sink.offSel == OffDisabled) begin
      next_cur.phase = LSCR_ON;
      next_cur.count = 4'h0;
    end else if (sink.tick) begin
      case (cur.phase)
        LSCR_ON: begin
          if (cur.count + 4'h1 >= onTicks) begin
            next_cur.phase = LSCR_OFF;
            next_cur.count = 4'h0;
          end else next_cur.count = cur.count + 4'h1;
        end
        LSCR_OFF: begin
          if (cur.count + 4'h1 >= offTicks) begin
            next_cur.phase = LSCR_ON;
            next_cur.count = 4'h0;
          end else next_cur.count = cur.count + 4'h1;
        end
        default: next_cur.phase = LSCR_ON;
      endcase
    end
    next_cur.out = sink.enable && (next_cur.phase == LSCR_ON);
  end

  always_ff @(posedge sysClk or negedge rst_n) begin
    if (!rst_n) cur <= '{phase: LSCR_ON, count: 4'h0, out: 1'b0};
    else cur <= next_cur;
  end
  assign sink.sinkOn = cur.out;

  steady_on_a: assert property (@(posedge sysClk) disable iff (!rst_n)
    (sink.enable && !sink.restart && sink.offSel == OffDisabled) |=> sink.sinkOn)
    else $error("sink not steady on with off interval disabled");
  off_when_disabled_a: assert property (@(posedge sysClk) disable iff (!rst_n)
    !sink.enable |=> !sink.sinkOn)
    else $error("sink on while disabled");
endmodule // lscr_sink_timer

/* lscr_host_model.sv */
`timescale 1ns/1ps
module lscr_host_model (
  // clock
  input  wire logic       sys_clk,
  // register port
  output logic            wrStrobe,
  output logic            rdStrobe,
  output logic      [7:0] regAddr,
  output logic      [7:0] wrData
);
  initial begin
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    regAddr  = 8'hFF;
    wrData   = 8'hFF;
  end
  // one-cycle strobe; released lines show the inverse so stale values never match
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wrStrobe <= w;
    rdStrobe <= ~w;
    regAddr  <= a;
    wrData   <= d;
    @(posedge sys_clk);
    wrStrobe <= 1'b0;
    rdStrobe <= 1'b0;
    regAddr  <= ~a;
    wrData   <= ~d;
  endtask
endmodule // lscr_host_model

/* lscr_regs_tb.sv */
`timescale 1ns/1ps
module lscr_regs_tb;
  import lscr_pkg::*;
  logic       sys_clk, rst_n, darkAmbient, dimFlag, dimTimeout;
  logic       wrStrobe, rdStrobe, rdValid, darkDacSquare, sinkDacSquare;
  logic [7:0] regAddr, wrData, rdData, e;
  logic [6:0] darkCode, sinkOn, maxC, dimC;
  logic [1:0] sinkStepProfile;
  logic [7:0] expQ[$];
  logic [7:0] addrs[4] = '{DarkMaxOffset, DarkDimOffset, FadeLawOffset, SinkEnableOffset};
  int         n_fail = 0;
  int         checks = 0;
  int         seed = 32'hfbc6;

  lscr_host_model host (.sys_clk, .wrStrobe, .rdStrobe, .regAddr, .wrData);
  lscr_regs DUT (.sys_clk, .rst_n, .wrStrobe, .rdStrobe, .regAddr, .wrData, .rdData,
    .rdValid, .darkAmbient, .dimFlag, .dimTimeout, .darkCode, .darkDacSquare,
    .sinkDacSquare, .sinkStepProfile, .sinkOn);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    expQ.push_back(x);
    host.access(1'b0, a, 8'h00);
  endtask
  // inputs pass a 2-flop sync and a register stage
  task automatic settle;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask
  task automatic lvl(input logic a, input logic f, input logic t);
    @(posedge sys_clk);
    darkAmbient <= a;
    dimFlag     <= f;
    dimTimeout  <= t;
    settle;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // read results come back in request order
  always @(posedge sys_clk) begin
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        n_fail++;
        $display("wrong value at %0t: got %h expected none", $time, rdData);
      end else
        cmp(rdData, expQ.pop_front());
    end
  end

  initial begin
    #400000;
    n_fail++;
    report_and_stop;
  end

  initial begin
    rst_n = 1'b0;
    darkAmbient = 1'b0;
    dimFlag = 1'b0;
    dimTimeout = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1;
    cmp({1'b0, sinkOn}, 8'h00);
    @(posedge sys_clk) rst_n <= 1'b1;
    foreach (addrs[i]) rd(addrs[i], ResetValue);
    rd(8'h20, 8'h00);
    $display("test reset_map done");
    wr(DarkMaxOffset, 8'hFF);
    rd(DarkMaxOffset, CodeMask);
    maxC = 7'($random(seed));
    dimC = 7'($random(seed));
    wr(DarkMaxOffset, {1'b1, maxC});
    wr(DarkDimOffset, {1'b1, dimC});
    wr(8'h20, 8'h55);
    rd(DarkMaxOffset, {1'b0, maxC});
    rd(DarkDimOffset, {1'b0, dimC});
    lvl(1'b1, 1'b0, 1'b0);
    cmp({1'b0, darkCode}, {1'b0, maxC});
    lvl(1'b1, 1'b1, 1'b0);
    cmp({1'b0, darkCode}, {1'b0, dimC});
    lvl(1'b1, 1'b0, 1'b1);
    cmp({1'b0, darkCode}, {1'b0, dimC});
    lvl(1'b0, 1'b1, 1'b1);
    cmp({1'b0, darkCode}, {1'b0, maxC});
    lvl(1'b1, 1'b0, 1'b0);
    wr(DarkMaxOffset, {1'b0, CodeZero});
    settle;
    cmp({1'b0, darkCode}, {1'b0, CodeZero});
    wr(DarkMaxOffset, {1'b0, CodeFull});
    settle;
    cmp({1'b0, darkCode}, {1'b0, CodeFull});
    $display("test dark_codes done");
    for (int i = 0; i < 4; i++) begin
      wr(FadeLawOffset, {6'h3F, 2'(i)});
      rd(FadeLawOffset, {6'h00, 2'(i)});
      settle;
      cmp({7'h00, sinkDacSquare}, {7'h00, i != 0});
      cmp({7'h00, darkDacSquare}, {7'h00, i != 0});
      cmp({6'h00, sinkStepProfile}, 8'((i == 0) ? 0 : i - 1));
    end
    $display("test fade_law done");
    wr(SinkEnableOffset, 8'hFF);
    rd(SinkEnableOffset, SinkMask);
    settle;
    cmp({1'b0, sinkOn}, SinkMask);
    repeat (40) @(posedge sys_clk);
    cmp({1'b0, sinkOn}, SinkMask);
    for (int n = 0; n < NumSinks; n++) begin
      wr(SinkEnableOffset, 8'h01 << n);
      settle;
      cmp({1'b0, sinkOn}, 8'h01 << n);
    end
    e = 8'($random(seed));
    wr(SinkEnableOffset, e);
    settle;
    cmp({1'b0, sinkOn}, e & SinkMask);
    wr(SinkEnableOffset, 8'h00);
    settle;
    cmp({1'b0, sinkOn}, 8'h00);
    $display("test sinks done");
    // reset in mid-run must clear enables and codes
    wr(SinkEnableOffset, 8'h7F);
    settle;
    cmp({1'b0, sinkOn}, SinkMask);
    @(posedge sys_clk) rst_n <= 1'b0;
    @(posedge sys_clk) rst_n <= 1'b1;
    #1;
    cmp({1'b0, sinkOn}, 8'h00);
    cmp({1'b0, darkCode}, 8'h00);
    cmp({6'h00, sinkStepProfile}, 8'h00);
    rd(SinkEnableOffset, ResetValue);
    $display("test mid_reset done");
    repeat (4) @(posedge sys_clk);
    if (expQ.size() != 0)
      n_fail++;
    report_and_stop;
  end
endmodule // lscr_regs_tb
